// ### logic/asc_pkg.sv
// package for the async memory strobe controller
// assumes one clock domain, hclk at 25 MHz
package asc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam logic [31:0] REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] REG_RTIME = 32'h0000_0004;
    localparam logic [31:0] REG_WTIME = 32'h0000_0008;
    localparam logic [31:0] REG_ADDR = 32'h0000_000c;
    localparam logic [31:0] REG_WDATA_LO = 32'h0000_0010;
    localparam logic [31:0] REG_WDATA_HI = 32'h0000_0014;
    localparam logic [31:0] REG_RDATA_LO = 32'h0000_0018;
    localparam logic [31:0] REG_RDATA_HI = 32'h0000_001c;
    localparam logic [31:0] REG_STATUS = 32'h0000_0020;
    localparam logic [31:0] REG_CLKSEL = 32'h0000_0024;
    // ctrl fields
    localparam int unsigned CTRL_GO_BIT = 0;
    localparam int unsigned CTRL_WRITE_BIT = 1;
    localparam int unsigned CTRL_BE_LSB = 8;
    localparam int unsigned CTRL_CE_LSB = 16;
    // timing register fields: setup, strobe, hold
    localparam int unsigned TIME_W = 6;
    localparam int unsigned SETUP_LSB = 0;
    localparam int unsigned STROBE_LSB = 8;
    localparam int unsigned HOLD_LSB = 16;
    localparam logic [31:0] TIME_RESET = 32'h0001_0401;
    // status fields
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_DONE_BIT = 1;
    localparam int unsigned STAT_EXT_BIT = 2;
    // clock source select codes
    localparam logic [1:0] CLKSEL_EXT = 2'h0;
    localparam logic [1:0] CLKSEL_DIV4 = 2'h1;
    localparam logic [1:0] CLKSEL_DIV6 = 2'h2;
    localparam int unsigned DIV4 = 4;
    localparam int unsigned DIV6 = 6;
    // ready is recognised this many cycles before strobe end
    localparam int unsigned RDY_LOOKAHEAD = 2;
    typedef enum logic [4:0] {
        ASC_IDLE = 5'b00001,
        ASC_SETUP = 5'b00010,
        ASC_STROBE = 5'b00100,
        ASC_HOLD = 5'b01000,
        ASC_DONE = 5'b10000
    } asc_state_e;
endpackage

// ### logic/asc_tick_gen.sv
// interface clock tick generator: one tick per interface clock cycle
// assumes ext clock input is already synchronised to hclk
`timescale 1ns/100ps
module asc_tick_gen
    import asc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] clk_sel,
    input wire logic ext_clk_sync,
    output logic tick,
    output logic iface_clk_out_primary
);
    logic [2:0] cnt_q;
    logic ext_d1_q;
    logic [2:0] lim;
    logic out_q;

    always_comb begin
        lim = (clk_sel == CLKSEL_DIV6) ? 3'(DIV6 - 1) : 3'(DIV4 - 1);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 3'h0;
        end else if (cnt_q >= lim) begin
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_d1_q <= 1'b0;
        end else begin
            ext_d1_q <= ext_clk_sync;
        end
    end

    // tick marks a rising edge of the selected interface clock
    always_comb begin
        if (clk_sel == CLKSEL_EXT) begin
            tick = ext_clk_sync & ~ext_d1_q;
        end else begin
            tick = (cnt_q == 3'h0);
        end
    end

    // rises two hclk after a tick, in step with the registered strobes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_q <= 1'b0;
        end else if (clk_sel == CLKSEL_EXT) begin
            out_q <= ext_d1_q;
        end else begin
            out_q <= (cnt_q != 3'h0) && (cnt_q <= ((lim + 3'h1) >> 1));
        end
    end

    assign iface_clk_out_primary = out_q;
endmodule

// ### logic/asc_ctrl.sv
// async memory strobe controller: setup/strobe/hold cycle engine
// assumes an ahb-lite master on hclk; memory pins face async devices
`timescale 1ns/100ps
module asc_ctrl
    import asc_pkg::*;
#(
    parameter int DATA_W = 64,
    parameter int BE_W = 8,
    parameter int ADDR_W = 20,
    parameter int CE_W = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic iface_input_clock,
    input wire logic ext_ready_in,
    output logic iface_clk_out_primary,
    output logic [CE_W-1:0] chip_enable_n,
    output logic [BE_W-1:0] byte_enable_n,
    output logic [ADDR_W-1:0] mem_addr_bus,
    input wire logic [DATA_W-1:0] mem_data_in,
    output logic [DATA_W-1:0] mem_data_out,
    output logic mem_data_oe,
    output logic output_enable_n,
    output logic read_strobe_n,
    output logic write_strobe_n
);
    asc_state_e st_q;
    logic [31:0] ctrl_q, rtime_q, wtime_q, addr_q;
    logic [63:0] wdata_q, rdata_q;
    logic [1:0] clksel_q;
    logic done_q, ext_q;
    logic ap_q, aw_q;
    logic [31:0] aa_q;
    logic rdy_s1_q, rdy_s2_q;
    logic eck_s1_q, eck_s2_q;
    logic tick;
    logic [TIME_W-1:0] cnt_q;
    logic waiting_q;
    logic wr_q;
    logic go;
    logic [TIME_W-1:0] setup_n, strobe_n, hold_n;

    asc_tick_gen i_asc_tick_gen (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_sel(clksel_q),
        .ext_clk_sync(eck_s2_q),
        .tick(tick),
        .iface_clk_out_primary(iface_clk_out_primary)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdy_s1_q <= 1'b1;
            rdy_s2_q <= 1'b1;
            eck_s1_q <= 1'b0;
            eck_s2_q <= 1'b0;
        end else begin
            rdy_s1_q <= ext_ready_in;
            rdy_s2_q <= rdy_s1_q;
            eck_s1_q <= iface_input_clock;
            eck_s2_q <= eck_s1_q;
        end
    end

    // ahb-lite slave, zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q <= 1'b0;
            aw_q <= 1'b0;
            aa_q <= 32'h0;
        end else if (hready) begin
            ap_q <= hsel & htrans[1];
            aw_q <= hwrite;
            aa_q <= haddr;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign go = ap_q && aw_q && (aa_q == REG_CTRL) && hwdata[CTRL_GO_BIT]
                && (st_q == ASC_IDLE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= 32'h0;
            rtime_q <= TIME_RESET;
            wtime_q <= TIME_RESET;
            addr_q <= 32'h0;
            wdata_q <= 64'h0;
            clksel_q <= CLKSEL_DIV4;
        end else if (ap_q && aw_q) begin
            unique case (aa_q)
                REG_CTRL: ctrl_q <= hwdata;
                REG_RTIME: rtime_q <= hwdata;
                REG_WTIME: wtime_q <= hwdata;
                REG_ADDR: addr_q <= hwdata;
                REG_WDATA_LO: wdata_q[31:0] <= hwdata;
                REG_WDATA_HI: wdata_q[63:32] <= hwdata;
                REG_CLKSEL: clksel_q <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        hrdata = 32'h0;
        unique case (aa_q)
            REG_CTRL: hrdata = ctrl_q;
            REG_RTIME: hrdata = rtime_q;
            REG_WTIME: hrdata = wtime_q;
            REG_ADDR: hrdata = addr_q;
            REG_WDATA_LO: hrdata = wdata_q[31:0];
            REG_WDATA_HI: hrdata = wdata_q[63:32];
            REG_RDATA_LO: hrdata = rdata_q[31:0];
            REG_RDATA_HI: hrdata = rdata_q[63:32];
            REG_STATUS: hrdata = {29'h0, ext_q, done_q,
                                  st_q != ASC_IDLE};
            REG_CLKSEL: hrdata = {30'h0, clksel_q};
            default: hrdata = 32'h0;
        endcase
    end

    always_comb begin
        if (wr_q) begin
            setup_n = wtime_q[SETUP_LSB +: TIME_W];
            strobe_n = wtime_q[STROBE_LSB +: TIME_W];
            hold_n = wtime_q[HOLD_LSB +: TIME_W];
        end else begin
            setup_n = rtime_q[SETUP_LSB +: TIME_W];
            strobe_n = rtime_q[STROBE_LSB +: TIME_W];
            hold_n = rtime_q[HOLD_LSB +: TIME_W];
        end
    end

    // zero counts act as one cycle; a zero-length phase is not usable
    function automatic logic [TIME_W-1:0] at_least1(
        input logic [TIME_W-1:0] v);
        at_least1 = (v == '0) ? TIME_W'(1) : v;
    endfunction

    // cycle engine; cnt_q counts interface cycles up through setup and hold, down through strobe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ASC_IDLE;
            cnt_q <= '0;
            wr_q <= 1'b0;
            waiting_q <= 1'b0;
            ext_q <= 1'b0;
        end else begin
            unique case (st_q)
                ASC_IDLE: if (go) begin
                    wr_q <= hwdata[CTRL_WRITE_BIT];
                    waiting_q <= 1'b0;
                    ext_q <= 1'b0;
                    st_q <= ASC_SETUP;
                    cnt_q <= '0;
                end
                ASC_SETUP: if (tick) begin
                    // first tick only aligns; full setup cycles follow
                    if (cnt_q >= at_least1(setup_n)) begin
                        st_q <= ASC_STROBE;
                        cnt_q <= at_least1(strobe_n);
                    end else begin
                        cnt_q <= cnt_q + TIME_W'(1);
                    end
                end
                ASC_STROBE: if (tick) begin
                    // ready checked at tick
                    // strobes under three cycles are never stretched
                    if (cnt_q == TIME_W'(RDY_LOOKAHEAD + 1) && !rdy_s2_q
                        && !waiting_q) begin
                        waiting_q <= 1'b1;
                        ext_q <= 1'b1;
                    end else if (waiting_q) begin
                        if (rdy_s2_q) begin
                            waiting_q <= 1'b0;
                            cnt_q <= cnt_q - TIME_W'(1);
                        end
                    end else if (cnt_q <= TIME_W'(1)) begin
                        st_q <= ASC_HOLD;
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q - TIME_W'(1);
                    end
                end
                ASC_HOLD: if (tick) begin
                    if (cnt_q + TIME_W'(1) >= at_least1(hold_n)) begin
                        st_q <= ASC_DONE;
                    end else begin
                        cnt_q <= cnt_q + TIME_W'(1);
                    end
                end
                ASC_DONE: st_q <= ASC_IDLE;
                default: st_q <= ASC_IDLE;
            endcase
        end
    end

    // done is sticky until the next start; setting wins over the clear by a start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_q <= 1'b0;
        end else if (st_q == ASC_DONE) begin
            done_q <= 1'b1;
        end else if (go) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 64'h0;
        end else if (st_q == ASC_STROBE && tick && !wr_q && !waiting_q
                     && cnt_q <= TIME_W'(1)) begin
            rdata_q <= 64'(mem_data_in);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
        end else begin
            read_strobe_n <= !(st_q == ASC_STROBE && !wr_q);
            write_strobe_n <= !(st_q == ASC_STROBE && wr_q);
        end
    end

    // select group held through all phases
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chip_enable_n <= '1;
            byte_enable_n <= '1;
            mem_addr_bus <= '0;
            mem_data_out <= '0;
            mem_data_oe <= 1'b0;
            output_enable_n <= 1'b1;
        end else if (st_q == ASC_IDLE || st_q == ASC_DONE) begin
            chip_enable_n <= '1;
            byte_enable_n <= '1;
            mem_data_oe <= 1'b0;
            output_enable_n <= 1'b1;
        end else begin
            chip_enable_n <= ~(CE_W'(1) << ctrl_q[CTRL_CE_LSB +: 2]);
            byte_enable_n <= ~ctrl_q[CTRL_BE_LSB +: BE_W];
            mem_addr_bus <= addr_q[ADDR_W-1:0];
            mem_data_out <= wdata_q[DATA_W-1:0];
            mem_data_oe <= wr_q;
            output_enable_n <= wr_q;
        end
    end

    // strobe never active outside an access
    property p_strobe_idle;
        @(posedge hclk) disable iff (!hresetn)
        (st_q == ASC_IDLE) |=> read_strobe_n && write_strobe_n;
    endproperty
    a_strobe_idle: assert property (p_strobe_idle)
        else $error("strobe active while idle");

    property p_ready_ignored;
        @(posedge hclk) disable iff (!hresetn)
        $rose(waiting_q) |-> $past(tick) && $past(st_q) == ASC_STROBE
            && $past(cnt_q) == TIME_W'(RDY_LOOKAHEAD + 1);
    endproperty
    a_ready_ignored: assert property (p_ready_ignored)
        else $error("ready honoured outside strobe check point");

    property p_stretch_hold;
        @(posedge hclk) disable iff (!hresetn)
        (waiting_q && !rdy_s2_q) |=> st_q == ASC_STROBE;
    endproperty
    a_stretch_hold: assert property (p_stretch_hold)
        else $error("strobe ended while ready low");

    property p_ce_during_strobe;
        @(posedge hclk) disable iff (!hresetn)
        !read_strobe_n |-> chip_enable_n != '1;
    endproperty
    a_ce_during_strobe: assert property (p_ce_during_strobe)
        else $error("read strobe without chip enable");

    property p_wdata_oe;
        @(posedge hclk) disable iff (!hresetn)
        !write_strobe_n |-> mem_data_oe && output_enable_n;
    endproperty
    a_wdata_oe: assert property (p_wdata_oe)
        else $error("write strobe without data drive");

    property p_hold_after;
        @(posedge hclk) disable iff (!hresetn)
        $rose(read_strobe_n) |-> chip_enable_n != '1;
    endproperty
    a_hold_after: assert property (p_hold_after)
        else $error("select dropped with read strobe");

    property p_wr_hold_after;
        @(posedge hclk) disable iff (!hresetn)
        $rose(write_strobe_n) |-> mem_data_oe;
    endproperty
    a_wr_hold_after: assert property (p_wr_hold_after)
        else $error("write data dropped with strobe");

    property p_oe_read;
        @(posedge hclk) disable iff (!hresetn)
        !read_strobe_n |-> !output_enable_n && !mem_data_oe;
    endproperty
    a_oe_read: assert property (p_oe_read)
        else $error("output enable wrong during read");

    property p_strobe_on_tick;
        @(posedge hclk) disable iff (!hresetn)
        ($changed(read_strobe_n) || $changed(write_strobe_n))
            |-> $past(tick, 2);
    endproperty
    a_strobe_on_tick: assert property (p_strobe_on_tick)
        else $error("strobe moved away from an interface edge");
endmodule

// ### bench/asc_sram_model.sv
// async sram model plus a wait-state source on the ready line
// assumes registered strobes and selects from the controller on hclk
`timescale 1ns/100ps
module asc_sram_model #(
    parameter int DATA_W = 64,
    parameter int BE_W = 8
) (
    input wire logic hclk,
    input wire logic [3:0] chip_enable_n,
    input wire logic [BE_W-1:0] byte_enable_n,
    input wire logic [19:0] mem_addr_bus,
    input wire logic [DATA_W-1:0] mem_data_out,
    input wire logic output_enable_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [31:0] low_cycles,
    output logic [DATA_W-1:0] mem_data_in,
    output logic ext_ready_in
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] last = '0;
    logic stb_q = 1'b1;
    int cnt = 0;
    initial begin
        foreach (mem[i]) mem[i] = '0;
        ext_ready_in = 1'b1;
    end
    // only enabled byte lanes are stored
    always @(posedge write_strobe_n) begin
        for (int i = 0; i < BE_W; i++) begin
            if (!byte_enable_n[i] && !(&chip_enable_n))
                mem[mem_addr_bus[3:0]][i*8 +: 8] = mem_data_out[i*8 +: 8];
        end
    end
    // released bus shows inverse of last value, never a stale copy
    always @* begin
        if (!output_enable_n && !(&chip_enable_n))
            mem_data_in = mem[mem_addr_bus[3:0]];
        else
            mem_data_in = ~last;
    end
    always @(posedge hclk) begin
        if (!output_enable_n)
            last <= mem_data_in;
    end
    always @(posedge hclk) begin
        stb_q <= read_strobe_n & write_strobe_n;
        if (stb_q && !(read_strobe_n & write_strobe_n) && low_cycles > 0) begin
            ext_ready_in <= 1'b0;
            cnt <= low_cycles - 1;
        end else if (cnt > 0)
            cnt <= cnt - 1;
        else
            ext_ready_in <= 1'b1;
    end
endmodule

// ### bench/asc_ctrl_test.sv
// self-checking bench: ahb-lite master, pin monitor, sram partner
// assumes the controller's ahb slave answers with zero wait states
`timescale 1ns/100ps
module asc_ctrl_test;
    import asc_pkg::*;
    typedef struct {int sl; int sh; int wl; int wh; int hl; int hh;} asc_note_s;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic iface_input_clock = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic clk_out;
    logic ext_ready_in;
    logic [3:0] chip_enable_n;
    logic [7:0] byte_enable_n;
    logic [19:0] mem_addr_bus;
    logic [63:0] mem_data_in;
    logic [63:0] mem_data_out;
    logic mem_data_oe;
    logic output_enable_n;
    logic read_strobe_n;
    logic write_strobe_n;
    int low_cycles = 0;
    int fails = 0;
    int compares = 0;
    int ph = 0;
    int cs = 0;
    int cw = 0;
    int ch = 0;
    logic ps = 1'b1;
    logic pc = 1'b0;
    logic [31:0] seed;
    asc_note_s notes[$];
    always #20 hclk = ~hclk;
    // phase unrelated to hclk so the synchroniser is exercised
    initial begin
        #7;
        forever #200 iface_input_clock = ~iface_input_clock;
    end
    asc_ctrl i_asc_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .iface_input_clock(iface_input_clock), .ext_ready_in(ext_ready_in),
        .iface_clk_out_primary(clk_out), .chip_enable_n(chip_enable_n),
        .byte_enable_n(byte_enable_n), .mem_addr_bus(mem_addr_bus),
        .mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
        .mem_data_oe(mem_data_oe), .output_enable_n(output_enable_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n));
    asc_sram_model i_asc_sram_model (.hclk(hclk),
        .chip_enable_n(chip_enable_n), .byte_enable_n(byte_enable_n),
        .mem_addr_bus(mem_addr_bus), .mem_data_out(mem_data_out),
        .output_enable_n(output_enable_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .low_cycles(low_cycles),
        .mem_data_in(mem_data_in), .ext_ready_in(ext_ready_in));
    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rng(input string nm, input int v, int lo, int hi);
        compares++;
        if (v < lo || v > hi) begin
            fails++;
            $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, v);
        end
    endtask
    task automatic wt();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            complete_run();
        end
    endtask
    // address phase held until hready, then data phase until hready
    task automatic bus(input logic w, logic [31:0] a, d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wt();
        htrans <= 2'h0;
        hwdata <= d;
        wt();
        r = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic acc(input logic w, input int s, t, h, dv, lo, hi, rl,
                       output logic [31:0] r);
        int n;
        low_cycles <= rl;
        bus(1'b1, w ? REG_WTIME : REG_RTIME, 32'((h << 16) | (t << 8) | s), r);
        notes.push_back('{s*dv, (s+1)*dv, lo, hi, h*dv, h*dv+2});
        bus(1'b1, REG_CTRL, {14'h0, 2'h1, 8'hff, 6'h0, w, 1'b1}, r);
        n = 0;
        do begin
            bus(1'b0, REG_STATUS, 32'h0, r);
            n++;
        end while (r[STAT_DONE_BIT] !== 1'b1 && n < 300);
        if (n >= 300) begin
            fails++;
            complete_run();
        end
        repeat (12) @(posedge hclk);
    endtask
    // pin monitor: phase lengths of each access in hclk cycles
    always @(negedge hclk) begin
        // strobe moves only as clk_out rises
        if ((read_strobe_n & write_strobe_n) !== ps)
            chk("clk_rise", 32'h1, {30'h0, pc, clk_out});
        ps = read_strobe_n & write_strobe_n;
        pc = clk_out;
        if (&chip_enable_n) begin
            if (ph == 2) begin
                if (notes.size() == 0)
                    rng("note", 0, 1, 1);
                else begin
                    rng("setup", cs, notes[0].sl, notes[0].sh);
                    rng("strobe", cw, notes[0].wl, notes[0].wh);
                    rng("hold", ch, notes[0].hl, notes[0].hh);
                    void'(notes.pop_front());
                end
            end
            ph = 0;
            cs = 0;
            cw = 0;
            ch = 0;
        end else if (ph == 0) begin
            if (read_strobe_n & write_strobe_n)
                cs++;
            else begin
                ph = 1;
                cw = 1;
            end
        end else if (ph == 1) begin
            chk("ce", 32'hd, {28'h0, chip_enable_n});
            chk("be", 32'h0, {24'h0, byte_enable_n});
            if (!read_strobe_n)
                chk("oe", 32'h0, {31'h0, output_enable_n});
            if (!write_strobe_n)
                chk("data_oe", 32'h1, {31'h0, mem_data_oe});
            if (read_strobe_n & write_strobe_n) begin
                ph = 2;
                ch = 1;
            end else
                cw++;
        end else
            ch++;
    end
    initial begin
        logic [31:0] r;
        logic [31:0] a;
        logic [63:0] d;
        seed = 32'h5e9fbfde;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, REG_RTIME, 32'h0, r);
        chk("rtime", TIME_RESET, r);
        bus(1'b0, REG_STATUS, 32'h0, r);
        chk("status", 32'h0, r);
        bus(1'b0, 32'h0000_0040, 32'h0, r);
        chk("unmapped", 32'h0, r);
        $display("test reset done");
        d = {32'($random(seed)), 32'($random(seed))};
        a = 32'($random(seed)) & 32'h000f_ffff;
        bus(1'b1, REG_ADDR, a, r);
        bus(1'b1, REG_WDATA_LO, d[31:0], r);
        bus(1'b1, REG_WDATA_HI, d[63:32], r);
        acc(1'b1, 2, 3, 2, 4, 12, 12, 0, r);
        acc(1'b0, 1, 4, 1, 4, 16, 16, 0, r);
        bus(1'b0, REG_RDATA_LO, 32'h0, r);
        chk("rdata_lo", d[31:0], r);
        bus(1'b0, REG_RDATA_HI, 32'h0, r);
        chk("rdata_hi", d[63:32], r);
        chk("mem_addr", a, {12'h0, mem_addr_bus});
        $display("test write_read done");
        acc(1'b0, 1, 4, 1, 4, 40, 44, 24, r);
        chk("stretched", 32'h1, {31'h0, r[STAT_EXT_BIT]});
        acc(1'b0, 1, 8, 1, 4, 32, 32, 8, r);
        chk("not_stretched", 32'h0, {31'h0, r[STAT_EXT_BIT]});
        $display("test ready done");
        bus(1'b1, REG_CLKSEL, {30'h0, CLKSEL_DIV6}, r);
        acc(1'b1, 1, 2, 1, 6, 12, 12, 0, r);
        bus(1'b1, REG_CLKSEL, {30'h0, CLKSEL_EXT}, r);
        acc(1'b1, 1, 2, 1, 10, 20, 20, 0, r);
        $display("test clock_source done");
        rng("pending", notes.size(), 0, 0);
        complete_run();
    end
endmodule
